//--- design/mos_defines.svh
// constants of the multifunction output selector: codes, defaults, timing
// assumes a 200 MHz system clock; included by the package and the modules
`ifndef MOS_DEFINES_SVH
`define MOS_DEFINES_SVH

// field widths
`define MOS_CODE_W       5
`define MOS_VAL_W        16
`define MOS_TEMP_W       8
`define MOS_NUM_OUT      4
`define MOS_NUM_AUX      3

// output index: relay first, then the three terminals
`define MOS_IDX_RELAY    0

// function codes
`define MOS_FC_NONE      5'h00
`define MOS_FC_RUNNING   5'h01
`define MOS_FC_FREQ_HIT  5'h02
`define MOS_FC_ZERO_CMD  5'h03
`define MOS_FC_TORQUE    5'h04
`define MOS_FC_BLOCK     5'h05
`define MOS_FC_LOW_VOLT  5'h06
`define MOS_FC_EXT_CMD   5'h07
`define MOS_FC_FAULT     5'h08
`define MOS_FC_DESIRED1  5'h09
`define MOS_FC_SEQ_RUN   5'h0A
`define MOS_FC_SEQ_STEP  5'h0B
`define MOS_FC_SEQ_DONE  5'h0C
`define MOS_FC_SEQ_PAUSE 5'h0D
`define MOS_FC_TERM_CNT  5'h0E
`define MOS_FC_PRE_CNT   5'h0F
`define MOS_FC_AUX_BASE  5'h10
`define MOS_FC_HEATSINK  5'h13
`define MOS_FC_READY     5'h14
`define MOS_FC_ESTOP     5'h15
`define MOS_FC_DESIRED2  5'h16
`define MOS_FC_BRAKE_AID 5'h17
`define MOS_FC_ZERO_OUT  5'h18
`define MOS_FC_UNDER_CUR 5'h19
`define MOS_FC_VOLT_OUT  5'h1A
`define MOS_FC_FB_ERR    5'h1B
`define MOS_FC_USER_LV   5'h1C
`define MOS_FC_BRAKE     5'h1D
`define MOS_FC_LAST      5'h1D

// factory defaults of the four codes
`define MOS_DEF_RELAY    5'h08
`define MOS_DEF_TERM1    5'h01
`define MOS_DEF_TERM2    5'h02
`define MOS_DEF_TERM3    5'h14

// heatsink warning level in degrees C
`define MOS_HEATSINK_DEGC 8'h55

// timing
`define MOS_CLK_PERIOD_NS 5
`define MOS_TICK_TIME_NS  1000
`define MOS_TICK_CYCLES   (`MOS_TICK_TIME_NS / `MOS_CLK_PERIOD_NS)
`define MOS_PULSE_TIME_MS 500
`define MOS_PULSE_CYCLES  \
   ((`MOS_PULSE_TIME_MS * 1000000 + `MOS_CLK_PERIOD_NS - 1) / `MOS_CLK_PERIOD_NS)

`endif

//--- design/mos_pkg.sv
// types shared by the multifunction output selector
// assumes mos_defines.svh is on the include path
`include "mos_defines.svh"

package mos_pkg;

   // drive status flags, all produced on the system clock
   typedef struct packed {
      logic                      run_cmd;
      logic                      output_active;
      logic                      over_torque;
      logic                      output_block;
      logic                      supply_low_voltage;
      logic                      ext_cmd_source;
      logic                      fault_present;
      logic                      seq_running;
      logic                      seq_paused;
      logic                      seq_step_evt;
      logic                      seq_cycle_evt;
      logic                      power_on;
      logic                      abnormal;
      logic                      emergency_stop;
      logic                      brake_assist;
      logic                      under_current;
      logic                      user_low_voltage;
      logic                      stop_cmd;
      logic                      output_voltage_present;
      logic                      feedback_error;
      logic [`MOS_NUM_AUX-1:0]   aux_motor;
   } mos_status_t;

   // frequencies in 0.01 Hz steps, counts, heatsink temperature
   typedef struct packed {
      logic [`MOS_VAL_W-1:0]     out_freq;
      logic [`MOS_VAL_W-1:0]     cmd_freq;
      logic [`MOS_VAL_W-1:0]     min_freq;
      logic [`MOS_VAL_W-1:0]     desired_freq_one;
      logic [`MOS_VAL_W-1:0]     desired_freq_two;
      logic [`MOS_VAL_W-1:0]     brake_release_freq;
      logic [`MOS_VAL_W-1:0]     brake_engage_freq;
      logic [`MOS_VAL_W-1:0]     count_value;
      logic [`MOS_VAL_W-1:0]     terminal_count;
      logic [`MOS_VAL_W-1:0]     prelim_count;
      logic [`MOS_TEMP_W-1:0]    heatsink_temp;
   } mos_thresh_t;

   typedef logic [`MOS_CODE_W-1:0] mos_code_t;

endpackage

//--- design/mos_pulse_stretch.sv
// stretches a one-cycle event into a level of fixed length
// assumes the event comes from logic on the same clock
`include "mos_defines.svh"

module mos_pulse_stretch #(
   parameter int unsigned HOLD_CYCLES = `MOS_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic clk_sys_in,
   input  wire logic nrst_in,
   // event and stretched level
   input  wire logic evt_in,
   output logic      busy_out
);

   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(HOLD_CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;

   if (HOLD_CYCLES < 2) begin : g_bad
      $error("mos_pulse_stretch: HOLD_CYCLES must be at least 2");
   end

   // an event reloads the count, so a new step restarts the pulse
   assign cnt_nxt  = evt_in ? LOAD : (busy_r ? cnt_r - CW'(1) : cnt_r);
   assign busy_nxt = evt_in | (busy_r & (cnt_r != '0));

   // count register
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
      end
   end

   assign busy_out = busy_r;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   sequence s_evt;
      evt_in;
   endsequence

   sequence s_loaded;
      busy_r && cnt_r == LOAD;
   endsequence

   a_pulse_start: assert property (s_evt |=> s_loaded)
      else $error("stretch not loaded after event");
   a_pulse_count: assert property (busy_r && !evt_in && cnt_r != '0
         |=> busy_r && cnt_r == $past(cnt_r) - CW'(1))
      else $error("stretch count did not step down");
   a_pulse_end: assert property (busy_r && !evt_in && cnt_r == '0 |=> !busy_r)
      else $error("stretch did not end on time");

endmodule

//--- design/mos_output_select.sv
// multifunction output selector: one relay and three terminals, each
// driven by the drive condition its function code picks
// assumes status and thresholds come from logic on the same clock
`include "mos_defines.svh"

module mos_output_select #(
   parameter int unsigned TICK_CYCLES  = `MOS_TICK_CYCLES,
   parameter int unsigned PULSE_CYCLES = `MOS_PULSE_CYCLES
) (
   // clock and reset
   input  wire logic                       clk_sys_in,
   input  wire logic                       nrst_in,
   // function code configuration
   input  wire logic                       factory_reset_in,
   input  wire logic [`MOS_NUM_OUT-1:0]    code_wr_en_in,
   input  wire mos_pkg::mos_code_t         code_wr_data_in,
   // drive status and thresholds
   input  wire mos_pkg::mos_status_t       status_in,
   input  wire mos_pkg::mos_thresh_t       thresh_in,
   // output drivers
   output logic                            relay_energise_out,
   output logic                            status_terminal_one_out,
   output logic                            status_terminal_two_out,
   output logic                            status_terminal_three_out,
   // configuration readback and brake latch state
   output mos_pkg::mos_code_t [`MOS_NUM_OUT-1:0] code_out,
   output logic                            brake_engaged_out
);

   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam mos_pkg::mos_code_t CODE_DEF [`MOS_NUM_OUT] =
      '{`MOS_DEF_RELAY, `MOS_DEF_TERM1, `MOS_DEF_TERM2, `MOS_DEF_TERM3};

   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("mos_output_select: TICK_CYCLES must be at least 2");
   end

   logic [TW-1:0]                         tick_cnt_r;
   logic                                  tick_r;
   mos_pkg::mos_code_t [`MOS_NUM_OUT-1:0] code_r;
   logic [`MOS_NUM_OUT-1:0]               out_r;
   logic                                  brake_r;
   logic                                  brake_nxt;
   logic                                  stop_seen_r;
   logic                                  stop_seen_nxt;
   logic                                  step_pulse;
   logic                                  cycle_pulse;
   logic [31:0]                           cond_vec;
   logic [`MOS_NUM_OUT-1:0]               sel;
   logic                                  term_hit;
   logic                                  pre_hit;
   logic                                  brake_set;
   logic                                  brake_clr;

   // control tick divider
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end
      else
      begin
         tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + TW'(1);
         tick_r     <= (tick_cnt_r == TICK_LAST);
      end
   end

   mos_pulse_stretch #(
      .HOLD_CYCLES (PULSE_CYCLES)
   ) u_step_pulse (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .evt_in     (status_in.seq_step_evt),
      .busy_out   (step_pulse)
   );

   mos_pulse_stretch #(
      .HOLD_CYCLES (PULSE_CYCLES)
   ) u_cycle_pulse (
      .clk_sys_in (clk_sys_in),
      .nrst_in    (nrst_in),
      .evt_in     (status_in.seq_cycle_evt),
      .busy_out   (cycle_pulse)
   );

   // counter comparisons; preliminary drops once terminal is hit
   assign term_hit = thresh_in.count_value >= thresh_in.terminal_count;
   assign pre_hit  = (thresh_in.count_value >= thresh_in.prelim_count) & ~term_hit;

   // brake hysteresis: set wins, clear only after a stop
   assign brake_set     = thresh_in.out_freq >= thresh_in.brake_release_freq;
   assign brake_clr     = stop_seen_r & (thresh_in.out_freq <= thresh_in.brake_engage_freq);
   assign brake_nxt     = brake_set | (brake_r & ~brake_clr);
   assign stop_seen_nxt = brake_nxt & (stop_seen_r | status_in.stop_cmd);

   // condition vector indexed by function code
   assign cond_vec[`MOS_FC_NONE]      = 1'b0;
   assign cond_vec[`MOS_FC_RUNNING]   = status_in.output_active | status_in.run_cmd;
   assign cond_vec[`MOS_FC_FREQ_HIT]  = thresh_in.out_freq == thresh_in.cmd_freq;
   assign cond_vec[`MOS_FC_ZERO_CMD]  = thresh_in.cmd_freq < thresh_in.min_freq;
   assign cond_vec[`MOS_FC_TORQUE]    = status_in.over_torque;
   assign cond_vec[`MOS_FC_BLOCK]     = status_in.output_block;
   assign cond_vec[`MOS_FC_LOW_VOLT]  = status_in.supply_low_voltage;
   assign cond_vec[`MOS_FC_EXT_CMD]   = status_in.ext_cmd_source;
   assign cond_vec[`MOS_FC_FAULT]     = status_in.fault_present;
   assign cond_vec[`MOS_FC_DESIRED1]  = thresh_in.out_freq >= thresh_in.desired_freq_one;
   assign cond_vec[`MOS_FC_SEQ_RUN]   = status_in.seq_running;
   assign cond_vec[`MOS_FC_SEQ_STEP]  = step_pulse;
   assign cond_vec[`MOS_FC_SEQ_DONE]  = cycle_pulse;
   assign cond_vec[`MOS_FC_SEQ_PAUSE] = status_in.seq_paused;
   assign cond_vec[`MOS_FC_TERM_CNT]  = term_hit;
   assign cond_vec[`MOS_FC_PRE_CNT]   = pre_hit;
   assign cond_vec[`MOS_FC_AUX_BASE +: `MOS_NUM_AUX] = status_in.aux_motor;
   assign cond_vec[`MOS_FC_HEATSINK]  = thresh_in.heatsink_temp > `MOS_HEATSINK_DEGC;
   assign cond_vec[`MOS_FC_READY]     = status_in.power_on & ~status_in.abnormal;
   assign cond_vec[`MOS_FC_ESTOP]     = status_in.emergency_stop;
   assign cond_vec[`MOS_FC_DESIRED2]  = thresh_in.out_freq >= thresh_in.desired_freq_two;
   assign cond_vec[`MOS_FC_BRAKE_AID] = status_in.brake_assist;
   assign cond_vec[`MOS_FC_ZERO_OUT]  = thresh_in.out_freq == '0;
   assign cond_vec[`MOS_FC_UNDER_CUR] = status_in.under_current;
   // output voltage present and feedback error
   assign cond_vec[`MOS_FC_VOLT_OUT]  = status_in.output_voltage_present;
   assign cond_vec[`MOS_FC_FB_ERR]    = status_in.feedback_error;
   assign cond_vec[`MOS_FC_USER_LV]   = status_in.user_low_voltage;
   assign cond_vec[`MOS_FC_BRAKE]     = brake_r;
   // unused codes read as no function
   assign cond_vec[31:`MOS_FC_LAST+1] = '0;

   // per-output code register and selection
   for (genvar i = 0; i < `MOS_NUM_OUT; i++) begin : g_out
      assign sel[i] = cond_vec[code_r[i]];

      // defaults on reset or factory reset
      always_ff @(posedge clk_sys_in)
      begin
         if (!nrst_in || factory_reset_in)
            code_r[i] <= CODE_DEF[i];
         else if (code_wr_en_in[i])
            code_r[i] <= code_wr_data_in;
      end

      always_ff @(posedge clk_sys_in)
      begin
         if (!nrst_in)
            out_r[i] <= 1'b0;
         else if (tick_r)
            out_r[i] <= sel[i];
      end

      a_out_refresh: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
         tick_r |=> out_r[i] == $past(sel[i]))
         else $error("output not refreshed from its code on tick");
      a_out_hold: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
         !tick_r |=> $stable(out_r[i]))
         else $error("output changed between ticks");
      a_out_nofunc: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
         tick_r && (code_r[i] == `MOS_FC_NONE || code_r[i] > `MOS_FC_LAST)
         |=> !out_r[i])
         else $error("no-function code drove output high");
   end

   // brake latch, evaluated on the tick
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         brake_r     <= 1'b0;
         stop_seen_r <= 1'b0;
      end
      else if (tick_r)
      begin
         brake_r     <= brake_nxt;
         stop_seen_r <= stop_seen_nxt;
      end
   end

   // outputs straight from flip-flops
   assign relay_energise_out        = out_r[`MOS_IDX_RELAY];
   assign status_terminal_one_out   = out_r[1];
   assign status_terminal_two_out   = out_r[2];
   assign status_terminal_three_out = out_r[3];
   assign code_out                  = code_r;
   assign brake_engaged_out         = brake_r;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   sequence s_tick;
      tick_r;
   endsequence

   // tick on which the brake output is on and a stop was already seen
   sequence s_stop_armed;
      s_tick ##0 brake_r && stop_seen_r;
   endsequence

   a_tick_spacing: assert property (s_tick |=> !tick_r ##[0:300] tick_r)
      else $error("control tick missing or too close");
   a_code_default: assert property ($past(factory_reset_in)
         |-> code_r[`MOS_IDX_RELAY] == `MOS_DEF_RELAY && code_r[3] == `MOS_DEF_TERM3)
      else $error("codes not at factory defaults");
   a_term_defaults: assert property ($past(factory_reset_in)
         |-> code_r[1] == `MOS_DEF_TERM1 && code_r[2] == `MOS_DEF_TERM2)
      else $error("terminal codes not at factory defaults");
   // reset state, watched while reset is low
   a_reset_state: assert property (@(posedge clk_sys_in) disable iff (1'b0)
         !nrst_in |=> out_r == '0 && !brake_r && code_r[`MOS_IDX_RELAY] == `MOS_DEF_RELAY)
      else $error("state not cleared by reset");
   a_fault_relay: assert property (s_tick ##0 code_r[`MOS_IDX_RELAY] == `MOS_FC_FAULT
         && status_in.fault_present |=> relay_energise_out)
      else $error("fault not shown on relay");
   a_estop_relay: assert property (s_tick ##0 code_r[`MOS_IDX_RELAY] == `MOS_FC_ESTOP
         && status_in.emergency_stop |=> relay_energise_out)
      else $error("emergency stop not shown on relay");
   a_ready_term: assert property (s_tick ##0 code_r[3] == `MOS_FC_READY
         && status_in.power_on && !status_in.abnormal |=> status_terminal_three_out)
      else $error("drive ready not shown on terminal three");
   a_count_excl: assert property (s_tick ##0 code_r[2] == `MOS_FC_PRE_CNT
         && thresh_in.count_value >= thresh_in.terminal_count |=> !status_terminal_two_out)
      else $error("preliminary count output on at terminal count");
   a_brake_set: assert property (s_tick ##0 brake_set |=> brake_r)
      else $error("brake not released at release frequency");
   a_brake_keep: assert property (s_tick ##0 brake_r && !stop_seen_r |=> brake_r)
      else $error("brake output dropped without stop");
   a_brake_clear: assert property (s_stop_armed ##0 !brake_set
         && thresh_in.out_freq <= thresh_in.brake_engage_freq |=> !brake_r)
      else $error("brake output kept after stop at engage frequency");
   a_heatsink: assert property (s_tick ##0 code_r[1] == `MOS_FC_HEATSINK
         |=> status_terminal_one_out == ($past(thresh_in.heatsink_temp) > `MOS_HEATSINK_DEGC))
      else $error("heatsink warning level wrong");

endmodule

//--- tb/mos_load_model.sv
// load model: relay coil and three indicator inputs beyond the selector
// assumes the selector drives plain active-high levels on the system clock
module mos_load_model (
   // levels from the selector
   input  wire logic       relay_coil_in,
   input  wire logic [2:0] term_in,
   // what the load sees: contact closed, lamps lit
   output logic [3:0]      seen_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts follow the coil, lamps follow the terminals
   assign seen_out = {term_in, relay_coil_in};
endmodule

//--- tb/tb_top.sv
// bench of the output selector: reset check, code table loop, then edge cases and a mid-run reset
// assumes short tick and pulse parameters so the run stays brief
`include "mos_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned TICK  = 4;
   localparam int unsigned PULSE = 20;
   typedef struct packed { logic [4:0] code; logic exp; } mos_row_t;
   logic                     clk_sys_in;
   logic                     nrst_in;
   logic                     factory_reset_in;
   logic [3:0]               code_wr_en_in;
   mos_pkg::mos_code_t       code_wr_data_in;
   mos_pkg::mos_status_t     st;
   mos_pkg::mos_thresh_t     th;
   mos_pkg::mos_status_t     s_v;
   mos_pkg::mos_thresh_t     t_v;
   logic                     relay;
   logic [2:0]               term;
   logic                     brake;
   mos_pkg::mos_code_t [3:0] codes;
   logic [3:0]               seen;
   int                       failures;
   int                       n_tests;
   int                       i;
   int                       k;
   mos_row_t                 rows [29];

   mos_output_select #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE)) dut (
      .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .factory_reset_in(factory_reset_in),
      .code_wr_en_in(code_wr_en_in), .code_wr_data_in(code_wr_data_in),
      .status_in(st), .thresh_in(th), .relay_energise_out(relay),
      .status_terminal_one_out(term[0]), .status_terminal_two_out(term[1]),
      .status_terminal_three_out(term[2]), .code_out(codes), .brake_engaged_out(brake));

   mos_load_model load (.relay_coil_in(relay), .term_in(term), .seen_out(seen));

   // clock of 5 ns period
   initial
   begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end

   task automatic close_out();
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [4:0] e, input logic [4:0] g);
      n_tests++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // writes one code to the outputs picked by en
   task automatic wr(input logic [3:0] en, input logic [4:0] c);
      @(posedge clk_sys_in);
      code_wr_en_in <= en;
      code_wr_data_in <= c;
      @(posedge clk_sys_in);
      code_wr_en_in <= 4'h0;
   endtask

   // lets two ticks pass so outputs follow the inputs
   task automatic settle();
      repeat (2 * TICK + 2) @(posedge clk_sys_in);
      #1;
   endtask

   // inputs that make the condition of code c true or false
   task automatic mk(input logic [4:0] c, input logic on,
                     output mos_pkg::mos_status_t s, output mos_pkg::mos_thresh_t t);
      s = '0;
      t = '0;
      t.out_freq = 16'h0064;
      t.cmd_freq = 16'h00C8;
      t.min_freq = 16'h0032;
      t.desired_freq_one = 16'h012C;
      t.desired_freq_two = 16'h0190;
      t.brake_release_freq = 16'hFFFF;
      t.terminal_count = 16'h000A;
      t.prelim_count = 16'h0005;
      t.heatsink_temp = 8'h55;
      if (on)
      begin
         case (c)
            5'h01: s.run_cmd = 1'b1;
            5'h02: t.out_freq = t.cmd_freq;
            5'h03: t.cmd_freq = 16'h0020;
            5'h04: s.over_torque = 1'b1;
            5'h05: s.output_block = 1'b1;
            5'h06: s.supply_low_voltage = 1'b1;
            5'h07: s.ext_cmd_source = 1'b1;
            5'h08: s.fault_present = 1'b1;
            5'h09: t.out_freq = t.desired_freq_one;
            5'h0A: s.seq_running = 1'b1;
            5'h0D: s.seq_paused = 1'b1;
            5'h0E: t.count_value = t.terminal_count;
            5'h0F: t.count_value = t.prelim_count;
            5'h10, 5'h11, 5'h12: s.aux_motor[c - 5'h10] = 1'b1;
            5'h13: t.heatsink_temp = 8'h56;
            5'h14: s.power_on = 1'b1;
            5'h15: s.emergency_stop = 1'b1;
            5'h16: t.out_freq = t.desired_freq_two;
            5'h17: s.brake_assist = 1'b1;
            5'h18: t.out_freq = 16'h0000;
            5'h19: s.under_current = 1'b1;
            5'h1A: s.output_voltage_present = 1'b1;
            5'h1B: s.feedback_error = 1'b1;
            5'h1C: s.user_low_voltage = 1'b1;
            default: s = '0;
         endcase
      end
   endtask

   task automatic apply(input logic [4:0] c, input logic on);
      @(posedge clk_sys_in);
      mk(c, on, s_v, t_v);
      st <= s_v;
      th <= t_v;
   endtask

   // watchdog on the whole run
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      failures++;
      close_out();
   end

   initial
   begin
      failures = 0;
      n_tests = 0;
      nrst_in = 1'b0;
      factory_reset_in = 1'b0;
      code_wr_en_in = 4'h0;
      code_wr_data_in = 5'h00;
      mk(5'h00, 1'b0, s_v, t_v);
      st = s_v;
      th = t_v;
      rows = '{'{5'h00, 1'b0}, '{5'h01, 1'b1}, '{5'h02, 1'b1}, '{5'h03, 1'b1},
               '{5'h04, 1'b1}, '{5'h05, 1'b1}, '{5'h06, 1'b1}, '{5'h07, 1'b1},
               '{5'h08, 1'b1}, '{5'h09, 1'b1}, '{5'h0A, 1'b1}, '{5'h0D, 1'b1},
               '{5'h0E, 1'b1}, '{5'h0F, 1'b1}, '{5'h10, 1'b1}, '{5'h11, 1'b1},
               '{5'h12, 1'b1}, '{5'h13, 1'b1}, '{5'h14, 1'b1}, '{5'h15, 1'b1},
               '{5'h16, 1'b1}, '{5'h17, 1'b1}, '{5'h18, 1'b1}, '{5'h19, 1'b1},
               '{5'h1A, 1'b1}, '{5'h1B, 1'b1}, '{5'h1C, 1'b1}, '{5'h1E, 1'b0},
               '{5'h1F, 1'b0}};
      repeat (5) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      #1;
      chk("reset relay code", `MOS_DEF_RELAY, codes[0]);
      chk("reset term1 code", `MOS_DEF_TERM1, codes[1]);
      chk("reset term2 code", `MOS_DEF_TERM2, codes[2]);
      chk("reset term3 code", `MOS_DEF_TERM3, codes[3]);
      chk("reset outputs", 5'h00, {1'b0, seen});
      $display("test reset done");
      // each code except 0x0B, 0x0C and 0x1D on all four outputs, condition false then true
      for (i = 0; i < 29; i++)
      begin
         wr(4'hF, rows[i].code);
         for (k = 0; k < 2; k++)
         begin
            apply(rows[i].code, k[0]);
            settle();
            chk($sformatf("code %h level %0d", rows[i].code, k), {1'b0, {4{rows[i].exp & k[0]}}},
                {1'b0, seen}); // by row
         end
      end
      $display("test code table done");
      // factory reload wins over a write in the same cycle
      wr(4'hF, 5'h00);
      @(posedge clk_sys_in);
      factory_reset_in <= 1'b1;
      code_wr_en_in <= 4'hF;
      @(posedge clk_sys_in);
      factory_reset_in <= 1'b0;
      code_wr_en_in <= 4'h0;
      #1;
      chk("factory relay", `MOS_DEF_RELAY, codes[0]);
      chk("factory term3", `MOS_DEF_TERM3, codes[3]);
      $display("test factory done");
      // output follows a new condition within one tick
      apply(5'h00, 1'b0);
      settle();
      @(posedge clk_sys_in);
      st.fault_present <= 1'b1;
      for (k = 0; k < 20 && relay !== 1'b1; k++)
         @(posedge clk_sys_in);
      chk("tick latency ok", 5'h01, {4'h0, k >= 1 && k <= TICK + 1});
      $display("test tick done");
      // half-second pulses, shortened, for step and cycle events
      for (i = 0; i < 2; i++)
      begin
         wr(4'hF, 5'h0B + i[4:0]);
         apply(5'h00, 1'b0);
         settle();
         @(posedge clk_sys_in);
         st.seq_step_evt <= (i == 0);
         st.seq_cycle_evt <= (i == 1);
         @(posedge clk_sys_in);
         st <= '0;
         for (k = 0; k < 4 * TICK && relay !== 1'b1; k++)
            @(posedge clk_sys_in);
         for (k = 0; k < 2 * PULSE && relay === 1'b1; k++)
            @(posedge clk_sys_in);
         chk("pulse length ok", 5'h01, {4'h0, k >= PULSE - TICK && k <= PULSE + TICK});
      end
      $display("test pulse done");
      // terminal count reached clears the preliminary output
      wr(4'h1, 5'h0E);
      wr(4'hE, 5'h0F);
      apply(5'h0E, 1'b1);
      settle();
      chk("count split", 5'h01, {1'b0, seen});
      $display("test count done");
      // brake latch: set at release, kept until stop and engage
      wr(4'hF, 5'h1D);
      @(posedge clk_sys_in);
      th.brake_release_freq <= 16'h0190;
      th.brake_engage_freq <= 16'h0050;
      th.out_freq <= 16'h0190;
      settle();
      chk("brake set", 5'h1F, {brake, seen});
      @(posedge clk_sys_in);
      th.out_freq <= 16'h0040;
      settle();
      chk("brake held", 5'h1F, {brake, seen});
      @(posedge clk_sys_in);
      st.stop_cmd <= 1'b1;
      settle();
      settle();
      chk("brake clear", 5'h00, {brake, seen});
      $display("test brake done");
      // reset in mid-run drops the latched brake and restores the codes
      @(posedge clk_sys_in);
      th.out_freq <= 16'h0190;
      settle();
      chk("brake set again", 5'h1F, {brake, seen});
      @(posedge clk_sys_in);
      nrst_in <= 1'b0;
      @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      #1;
      chk("mid reset outputs", 5'h00, {brake, seen});
      chk("mid reset relay code", `MOS_DEF_RELAY, codes[0]);
      $display("test mid reset done");
      close_out();
   end
endmodule
